// *** src/pinchg_top.sv ***
// Pin-change interrupt block with a classic Wishbone register slave.
// Behaviour
// - One change-enable bit per implemented pin.
// - Power-on reset clears all change enables.
// - Master-clear pin function disables its detection.
// - Compare pins against latch captured on reads.
// - OR all enabled mismatches into change flag.
// - Enable clear: flag still sets, no request.
// - Port write also ends mismatch before clear.
// - Persisting mismatch keeps setting the flag.
// - Master clear leaves latch; flag re-sets.
// - Change during port access may be missed.
// - Enabled change wakes the core from sleep.
// - Port A bit four reads zero.
// - Analog-selected pin loses change detection.
`include "pinchg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module pinchg_top (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`PC_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic                       wb_ack_o,
    output logic      [31:0]           wb_dat_o,
    // Port pins and analog selection
    input  wire pinchg_pkg::pinchg_pair_t port_pins,
    input  wire pinchg_pkg::pinchg_pair_t analog_sel,
    // Port access strobes from the core
    input  wire logic                  port_a_rd,
    input  wire logic                  port_a_wr,
    input  wire logic                  port_b_rd,
    input  wire logic                  port_b_wr,
    // Configuration and system state
    input  wire logic                  master_clear_pin_cfg,
    input  wire logic                  master_clear_pin_rst,
    input  wire logic                  sleep_mode,
    // Requests
    output logic                       change_irq_req,
    output logic                       wake_req,
    output logic                       irq_o
);

    pinchg_pkg::pinchg_pair_t   pins_s;
    pinchg_pkg::pinchg_bus_st_t st_d;
    pinchg_pkg::pinchg_bus_st_t st_q;
    logic [7:0]  en_a;
    logic [7:0]  en_b;
    logic [7:0]  mism_a;
    logic [7:0]  mism_b;
    logic [7:0]  lat_a;
    logic [7:0]  lat_b;
    logic        port_op;
    logic        chg_set;
    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_ctl;
    logic [7:0]  ena_d;
    logic [7:0]  ena_q;
    logic [7:0]  enb_d;
    logic [7:0]  enb_q;
    logic        ien_d;
    logic        ien_q;
    logic        flag_d;
    logic        flag_q;
    logic [1:0]  sts_d;
    logic [1:0]  sts_q;
    logic [1:0]  msk_d;
    logic [1:0]  msk_q;
    logic        ack_d;
    logic        ack_q;
    logic [31:0] dat_d;
    logic [31:0] dat_q;
    logic        creq_d;
    logic        creq_q;
    logic        wake_d;
    logic        wake_q;
    logic        irq_d;
    logic        irq_q;

    // Pins are asynchronous; comparing them raw could flip the flag on a metastable bit.
    pinchg_sync #(
        .W (16)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (port_pins),
        .sync_out (pins_s)
    );

    always_comb
    begin
        en_a = ena_q & ~analog_sel.a;
        en_b = enb_q & ~analog_sel.b;
        if (master_clear_pin_cfg)
        begin
            en_a[`PC_PIN_MASTER_CLEAR_PIN] = 1'b0;
        end
    end

    pinchg_detect u_det_a (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .pins      (pins_s.a),
        .enable    (en_a),
        .capture   (port_a_rd | port_a_wr),
        .mismatch  (mism_a),
        .last_read (lat_a)
    );

    pinchg_detect u_det_b (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .pins      (pins_s.b),
        .enable    (en_b),
        .capture   (port_b_rd | port_b_wr),
        .mismatch  (mism_b),
        .last_read (lat_b)
    );

    // A port access reloads the latch, so its mismatch is dropped that cycle.
    assign port_op = port_a_rd | port_a_wr | port_b_rd | port_b_wr;
    assign chg_set = ((|mism_a) | (|mism_b)) & ~port_op;

    // Bus slave: one request, one acknowledge, then back to idle.
    assign req    = wb_cyc_i & wb_stb_i & (st_q == pinchg_pkg::BUS_IDLE);
    assign wr     = req & wb_we_i & wb_sel_i[0];
    assign rd     = req & ~wb_we_i;
    assign wr_ctl = wr & (wb_adr_i == `PC_OFF_CTL);

    always_comb
    begin
        st_d  = st_q;
        ack_d = 1'b0;
        case (st_q)
            pinchg_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    st_d  = pinchg_pkg::BUS_ACK;
                    ack_d = 1'b1;
                end
            end
            pinchg_pkg::BUS_ACK:
            begin
                st_d = pinchg_pkg::BUS_IDLE;
            end
            default:
            begin
                st_d = pinchg_pkg::BUS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        ena_d  = ena_q;
        enb_d  = enb_q;
        ien_d  = ien_q;
        flag_d = flag_q;
        sts_d  = sts_q;
        msk_d  = msk_q;
        dat_d  = dat_q;
        if (wr)
        begin
            case (wb_adr_i)
                `PC_OFF_ENA: ena_d = wb_dat_i[7:0] & `PC_IMPL_A;
                `PC_OFF_ENB: enb_d = wb_dat_i[7:0] & `PC_IMPL_B;
                `PC_OFF_CTL:
                begin
                    ien_d  = wb_dat_i[`PC_CTL_IEN];
                    flag_d = wb_dat_i[`PC_CTL_FLAG];
                end
                `PC_OFF_MSK: msk_d = wb_dat_i[1:0];
                default:     dat_d = dat_q;
            endcase
        end
        if (rd)
        begin
            dat_d = `PC_RST_WORD;
            case (wb_adr_i)
                `PC_OFF_ENA: dat_d[7:0] = ena_q;
                `PC_OFF_ENB: dat_d[7:0] = enb_q;
                `PC_OFF_CTL:
                begin
                    dat_d[`PC_CTL_IEN]  = ien_q;
                    dat_d[`PC_CTL_FLAG] = flag_q;
                end
                `PC_OFF_STS:
                begin
                    dat_d[1:0] = sts_q;
                    sts_d      = `PC_RST_STS;
                end
                `PC_OFF_MSK: dat_d[1:0] = msk_q;
                default:     dat_d = `PC_RST_WORD;
            endcase
        end
        // Master clear drops control but keeps enables, so a live mismatch re-flags.
        if (master_clear_pin_rst)
        begin
            ien_d  = 1'b0;
            flag_d = 1'b0;
            sts_d  = `PC_RST_STS;
            msk_d  = `PC_RST_STS;
        end
        // Hardware set wins over any clear in the same cycle.
        if (chg_set)
        begin
            flag_d             = 1'b1;
            sts_d[`PC_STS_CHG] = 1'b1;
        end
        wake_d = sleep_mode & ien_d & flag_d;
        if (wake_d)
        begin
            sts_d[`PC_STS_WAKE] = 1'b1;
        end
        creq_d = flag_d & ien_d;
        irq_d  = |(sts_d & msk_d);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q   <= pinchg_pkg::BUS_IDLE;
            ena_q  <= `PC_RST_BYTE;
            enb_q  <= `PC_RST_BYTE;
            ien_q  <= 1'b0;
            flag_q <= 1'b0;
            sts_q  <= `PC_RST_STS;
            msk_q  <= `PC_RST_STS;
            ack_q  <= 1'b0;
            dat_q  <= `PC_RST_WORD;
            creq_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            ena_q  <= ena_d;
            enb_q  <= enb_d;
            ien_q  <= ien_d;
            flag_q <= flag_d;
            sts_q  <= sts_d;
            msk_q  <= msk_d;
            ack_q  <= ack_d;
            dat_q  <= dat_d;
            creq_q <= creq_d;
            wake_q <= wake_d;
            irq_q  <= irq_d;
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = dat_q;
    assign change_irq_req = creq_q;
    assign wake_req       = wake_q;
    assign irq_o          = irq_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    bus_ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus acknowledge is not a single cycle after request.");
    ena_bit4_zero_a: assert property (ena_q[4] == 1'b0)
        else $error("Port A enable bit four is not zero.");
    flag_from_mism_a: assert property (chg_set |=> flag_q)
        else $error("Enabled mismatch did not set the change flag.");
    req_gating_a: assert property (change_irq_req == (flag_q && ien_q))
        else $error("Change request does not follow flag and enable.");
    master_clear_pin_pin_mask_a: assert property (master_clear_pin_cfg |-> !mism_a[`PC_PIN_MASTER_CLEAR_PIN])
        else $error("Master-clear pin still detects changes.");
    analog_mask_a: assert property (((mism_a & analog_sel.a) | (mism_b & analog_sel.b)) == 8'h00)
        else $error("Analog pin still detects changes.");
    latch_on_read_a: assert property (port_a_rd |=> lat_a == $past(pins_s.a))
        else $error("Port A read did not capture the pins.");
    latch_on_write_a: assert property (port_b_wr |=> lat_b == $past(pins_s.b))
        else $error("Port B write did not capture the pins.");
    latch_keep_master_clear_pin_a: assert property ((master_clear_pin_rst && !port_a_rd && !port_a_wr) |=> $stable(lat_a))
        else $error("Master clear altered the last-read latch.");
    flag_sticky_a: assert property ((flag_q && !wr_ctl && !master_clear_pin_rst) |=> flag_q)
        else $error("Change flag cleared without a write.");
    enable_reach_a: assert property ((ena_q[0] && !analog_sel.a[0] && (pins_s.a[0] != lat_a[0]))
        |-> mism_a[0])
        else $error("Enabled pin mismatch not detected.");
    wake_on_chg_a: assert property ((sleep_mode && ien_q && flag_q && !wr_ctl && !master_clear_pin_rst) |=> wake_req)
        else $error("Enabled change did not wake the core.");
    irq_mask_a: assert property (irq_o == |(sts_q & msk_q))
        else $error("Interrupt output disagrees with status and mask.");

    chg_req_c: cover property (chg_set ##1 change_irq_req);
    wake_c: cover property (sleep_mode ##1 wake_req);
    sts_clear_c: cover property ((rd && wb_adr_i == `PC_OFF_STS && sts_q != 2'h0) ##1 sts_q == 2'h0);

endmodule : pinchg_top

`default_nettype wire

// *** src/pinchg_cfg.svh ***
// Address map, field positions and reset values of the pin-change block.
`ifndef PINCHG_CFG_SVH
`define PINCHG_CFG_SVH

`define PC_ADR_W       8
`define PC_OFF_ENA     8'h00
`define PC_OFF_ENB     8'h04
`define PC_OFF_CTL     8'h08
`define PC_OFF_STS     8'h0C
`define PC_OFF_MSK     8'h10

`define PC_RST_BYTE    8'h00
`define PC_RST_STS     2'h0
`define PC_RST_WORD    32'h0000_0000
`define PC_IMPL_A      8'hEF
`define PC_IMPL_B      8'hF3
`define PC_PIN_MASTER_CLEAR_PIN    5

`define PC_CTL_FLAG    0
`define PC_CTL_IEN     3
`define PC_STS_CHG     0
`define PC_STS_WAKE    1

`endif

// *** src/pinchg_pkg.sv ***
// Types shared by the pin-change block.
`default_nettype none

package pinchg_pkg;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
    } pinchg_pair_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } pinchg_bus_st_t;

endpackage : pinchg_pkg

`default_nettype wire

// *** src/pinchg_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ns
`default_nettype none

module pinchg_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : pinchg_sync

`default_nettype wire

// *** src/pinchg_detect.sv ***
// Last-read latch and mismatch detector for one eight-pin port.
`include "pinchg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module pinchg_detect (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Port side
    input  wire logic [7:0] pins,
    input  wire logic [7:0] enable,
    input  wire logic       capture,
    // Result
    output logic      [7:0] mismatch,
    output logic      [7:0] last_read
);

    logic [7:0] lat_d;
    logic [7:0] lat_q;

    always_comb
    begin
        lat_d = lat_q;
        if (capture)
        begin
            lat_d = pins;
        end
    end

    // Only power-on reset touches the latch, so a master clear keeps it.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lat_q <= `PC_RST_BYTE;
        end
        else
        begin
            lat_q <= lat_d;
        end
    end

    assign mismatch  = enable & (pins ^ lat_q);
    assign last_read = lat_q;

endmodule : pinchg_detect

`default_nettype wire

// *** test/pinchg_pin_model.sv ***
// Far-side model: port pin levels and the core's port access strobes.
`timescale 1ns/1ns
`default_nettype none

module pinchg_pin_model (
    // Clock
    input  wire logic                    core_clk,
    // Pins and access strobes
    output var pinchg_pkg::pinchg_pair_t port_pins,
    output logic                         port_a_rd,
    output logic                         port_a_wr,
    output logic                         port_b_rd,
    output logic                         port_b_wr
);
    initial
    begin
        port_pins = 16'h0000;
        {port_a_rd, port_a_wr, port_b_rd, port_b_wr} = 4'h0;
    end

    // Pins move just after an edge, never in the same cycle as an access.
    task automatic flip(input int n);
        @(posedge core_clk);
        port_pins[n] <= ~port_pins[n];
    endtask : flip

    // One-cycle access pulse: 0 read A, 1 write A, 2 read B, 3 write B.
    task automatic access(input int k);
        @(posedge core_clk);
        {port_a_rd, port_a_wr, port_b_rd, port_b_wr} <= 4'h8 >> k;
        @(posedge core_clk);
        {port_a_rd, port_a_wr, port_b_rd, port_b_wr} <= 4'h0;
    endtask : access
endmodule : pinchg_pin_model
`default_nettype wire

// *** test/test_pinchg_top.sv ***
// Self-checking bench for the pin-change block and its register slave.
`timescale 1ns/1ns
`default_nettype none

module test_pinchg_top;
    logic                     core_clk = 1'b0;
    logic                     rstn;
    logic                     wb_cyc_i;
    logic                     wb_stb_i;
    logic                     wb_we_i;
    logic [7:0]               wb_adr_i;
    logic [3:0]               wb_sel_i;
    logic [31:0]              wb_dat_i;
    logic                     wb_ack_o;
    logic [31:0]              wb_dat_o;
    pinchg_pkg::pinchg_pair_t port_pins;
    pinchg_pkg::pinchg_pair_t analog_sel;
    logic                     port_a_rd;
    logic                     port_a_wr;
    logic                     port_b_rd;
    logic                     port_b_wr;
    logic                     master_clear_pin_cfg;
    logic                     master_clear_pin_rst;
    logic                     sleep_mode;
    logic                     change_irq_req;
    logic                     wake_req;
    logic                     irq_o;
    int                       failures = 0;
    int                       checks = 0;

    always #5 core_clk = ~core_clk;

    pinchg_pin_model m (.core_clk, .port_pins, .port_a_rd, .port_a_wr, .port_b_rd, .port_b_wr);

    pinchg_top pinchg_top_i (.core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .port_pins, .analog_sel, .port_a_rd,
        .port_a_wr, .port_b_rd, .port_b_wr, .master_clear_pin_cfg, .master_clear_pin_rst, .sleep_mode,
        .change_irq_req, .wake_req, .irq_o);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_lvl(input logic got, input logic exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : chk_lvl

    // Classic cycle; a read compares the returned byte and the zero upper bits.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        wb_sel_i <= 4'hF;
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        if (!w)
            chk(wb_dat_o, {24'h00_0000, d});
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        #20000;
        failures++;
        final_report();
    end

    initial
    begin
        rstn       <= 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_adr_i   <= 8'h00;
        wb_sel_i   <= 4'h0;
        wb_dat_i   <= 32'h0000_0000;
        analog_sel <= 16'h0000;
        {master_clear_pin_cfg, master_clear_pin_rst, sleep_mode} <= 3'h0;
        tick(10);
        rstn <= 1'b1;
        wb(0, 8'h00, 8'h00);
        wb(0, 8'h04, 8'h00);
        wb(0, 8'h08, 8'h00);
        wb(0, 8'h14, 8'h00);
        wb(1, 8'h00, 8'hFF);
        wb(0, 8'h00, 8'hEF);
        wb(1, 8'h04, 8'hFF);
        wb(0, 8'h04, 8'hF3);
        $display("test registers done");
        // Master-clear function on pin 5 and an analog pin 1 must stay silent.
        master_clear_pin_cfg <= 1'b1;
        analog_sel <= 16'h0200;
        m.flip(13);
        m.flip(9);
        tick(6);
        wb(0, 8'h08, 8'h00);
        m.access(0);
        m.flip(8);
        tick(6);
        wb(0, 8'h08, 8'h01);
        chk_lvl(change_irq_req, 1'b0);
        wb(1, 8'h08, 8'h00);
        wb(0, 8'h08, 8'h01);
        m.access(0);
        tick(3);
        wb(1, 8'h08, 8'h08);
        wb(0, 8'h08, 8'h08);
        chk_lvl(change_irq_req, 1'b0);
        $display("test flag and clear done");
        sleep_mode <= 1'b1;
        m.flip(0);
        tick(6);
        chk_lvl(change_irq_req, 1'b1);
        chk_lvl(wake_req, 1'b1);
        m.access(3);
        tick(3);
        wb(1, 8'h08, 8'h08);
        wb(0, 8'h08, 8'h08);
        chk_lvl(wake_req, 1'b0);
        sleep_mode <= 1'b0;
        wb(0, 8'h0C, 8'h03);
        wb(0, 8'h0C, 8'h00);
        $display("test wake done");
        wb(1, 8'h10, 8'h01);
        m.flip(8);
        tick(6);
        chk_lvl(irq_o, 1'b1);
        m.access(0);
        tick(3);
        wb(1, 8'h08, 8'h08);
        wb(0, 8'h0C, 8'h01);
        tick(2);
        chk_lvl(irq_o, 1'b0);
        $display("test status done");
        // The mismatch outlives a master clear because the latch is kept.
        m.flip(8);
        tick(6);
        master_clear_pin_rst <= 1'b1;
        tick(1);
        master_clear_pin_rst <= 1'b0;
        tick(3);
        wb(0, 8'h08, 8'h01);
        wb(0, 8'h00, 8'hEF);
        $display("test master clear done");
        // Port A write and port B read end a mismatch; an analog pin on B stays silent.
        m.access(1);
        tick(3);
        wb(1, 8'h08, 8'h08);
        wb(0, 8'h08, 8'h08);
        chk_lvl(change_irq_req, 1'b0);
        master_clear_pin_cfg <= 1'b0;
        analog_sel <= 16'h0001;
        m.flip(0);
        tick(6);
        wb(0, 8'h08, 8'h08);
        m.flip(1);
        tick(6);
        chk_lvl(change_irq_req, 1'b1);
        m.access(2);
        tick(3);
        wb(1, 8'h08, 8'h08);
        wb(0, 8'h08, 8'h08);
        $display("test other strobes done");
        // A second power-on reset clears the enables again.
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        wb(0, 8'h00, 8'h00);
        wb(0, 8'h04, 8'h00);
        $display("test power-on reset done");
        final_report();
    end
endmodule : test_pinchg_top
`default_nettype wire
